//--- rtl/sas_pkg.sv
// package: register map, field layout, reset values and timing of the adc sequencer
package sas_pkg;
  // data widths
  localparam int unsigned SAS_RES_W   = 10;
  localparam int unsigned SAS_CH_W    = 3;
  localparam int unsigned SAS_NCH     = 8;
  localparam int unsigned SAS_NPAIR   = 4;
  localparam int unsigned SAS_ADDR_W  = 12;
  localparam int unsigned SAS_IDX_W   = 10;
  // register indices; byte address is four times the index
  localparam logic [SAS_IDX_W-1:0] IDX_CONV_MODE_CTRL_1  = 10'h05e;
  localparam logic [SAS_IDX_W-1:0] IDX_CONV_MODE_CTRL_2  = 10'h05f;
  localparam logic [SAS_IDX_W-1:0] IDX_RESULT_CH0_4_LOW  = 10'h060;
  localparam logic [SAS_IDX_W-1:0] IDX_RESULT_CH0_4_HIGH = 10'h061;
  localparam logic [SAS_IDX_W-1:0] IDX_RESULT_CH1_5_LOW  = 10'h062;
  localparam logic [SAS_IDX_W-1:0] IDX_RESULT_CH1_5_HIGH = 10'h063;
  localparam logic [SAS_IDX_W-1:0] IDX_RESULT_CH2_6_LOW  = 10'h064;
  localparam logic [SAS_IDX_W-1:0] IDX_RESULT_CH2_6_HIGH = 10'h065;
  localparam logic [SAS_IDX_W-1:0] IDX_RESULT_CH3_7_LOW  = 10'h066;
  localparam logic [SAS_IDX_W-1:0] IDX_RESULT_CH3_7_HIGH = 10'h067;
  // conv_mode_ctrl_1 bit positions
  localparam int unsigned M1_END_BIT    = 7;
  localparam int unsigned M1_BUSY_BIT   = 6;
  localparam int unsigned M1_REPEAT_BIT = 5;
  localparam int unsigned M1_SCAN_BIT   = 4;
  localparam int unsigned M1_START_BIT  = 2;
  // conv_mode_ctrl_2 field positions
  localparam int unsigned M2_CH_LSB     = 0;
  localparam int unsigned M2_REF_BIT    = 3;
  localparam int unsigned M2_SPEED_LSB  = 4;
  // result low byte holds the two lsbs in bits 7:6
  localparam int unsigned RES_LOW_LSB   = 6;
  // reset values
  localparam logic                RST_FLAG    = 1'b0;
  localparam logic [SAS_CH_W-1:0] RST_CH_SEL  = 3'h0;
  localparam logic [1:0]          RST_SPEED   = 2'h0;
  localparam logic                RST_REF_ON  = 1'b0;
  // conversion time in clock states per speed setting
  localparam int unsigned CONV_STATES_0 = 160;
  localparam int unsigned CONV_STATES_1 = 320;
  localparam int unsigned CONV_STATES_2 = 640;
  localparam int unsigned CONV_STATES_3 = 1280;
  localparam int unsigned BIT_CYC_0 = CONV_STATES_0 / SAS_RES_W;
  localparam int unsigned BIT_CYC_1 = CONV_STATES_1 / SAS_RES_W;
  localparam int unsigned BIT_CYC_2 = CONV_STATES_2 / SAS_RES_W;
  localparam int unsigned BIT_CYC_3 = CONV_STATES_3 / SAS_RES_W;
  // sequencer states
  typedef enum logic [1:0] {
    SAS_IDLE  = 2'b00,
    SAS_BIT   = 2'b01,
    SAS_STORE = 2'b10
  } sas_state_t;
endpackage

//--- rtl/sas_top.sv
// module: successive-approximation adc sequencer with apb register access
`timescale 1ns/10ps
module sas_top
  import sas_pkg::*;
(
  // clock and reset
  input  wire logic                          CLK_SYS,
  input  wire logic                          RST,
  // apb slave
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [sas_pkg::SAS_ADDR_W-1:0] PADDR,
  input  wire logic [31:0]                   PWDATA,
  output logic      [31:0]                   PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  // analog front end
  input  wire logic                          CMP_GE,
  output logic      [sas_pkg::SAS_RES_W-1:0] LADDER_CODE,
  output logic      [sas_pkg::SAS_CH_W-1:0]  ANALOG_CH,
  output logic                               REF_GATE_ON,
  output logic                               CONV_DONE_IRQ,
  // shared digital port
  input  wire logic [sas_pkg::SAS_NCH-1:0]   PIN_LEVEL,
  output logic      [sas_pkg::SAS_NCH-1:0]   PORT_DIN
);
  import sas_pkg::*;

  // register state
  logic                 end_q, busy_q, repeat_q, scan_q;
  logic [SAS_CH_W-1:0]  ch_sel_q;
  logic                 ref_on_q;
  logic [1:0]           speed_q;
  logic [SAS_RES_W-1:0] res_q [SAS_NPAIR];
  // sequencer state
  sas_state_t           state_q, state_d;
  logic [SAS_RES_W-1:0] code_q, mask_q;
  logic [SAS_CH_W-1:0]  ch_q, last_q, first_q;
  logic [7:0]           cnt_q;
  logic                 irq_q;
  // apb answer
  logic                 pready_q, pslverr_q;
  logic [31:0]          prdata_q;
  // synchronisers
  logic                 cmp_m_q, cmp_s_q;
  logic [SAS_NCH-1:0]   pin_m_q, pin_s_q, port_q;

  // ---------------- apb decode ----------------
  wire                 acc_phase = PSEL & PENABLE;
  wire [SAS_IDX_W-1:0] idx       = PADDR[SAS_ADDR_W-1:2];
  wire                 aligned   = PADDR[1:0] == 2'b00;
  wire                 hit_m1    = aligned & (idx == IDX_CONV_MODE_CTRL_1);
  wire                 hit_m2    = aligned & (idx == IDX_CONV_MODE_CTRL_2);
  wire                 hit_res   = aligned & (idx >= IDX_RESULT_CH0_4_LOW)
                                 & (idx <= IDX_RESULT_CH3_7_HIGH);
  wire                 mapped    = hit_m1 | hit_m2 | hit_res;
  wire [1:0]           res_pair  = 2'(idx[2:1]);
  wire                 res_high  = idx[0];
  // the access completes at the edge where pready is seen high
  wire                 xfer      = acc_phase & pready_q;
  wire                 wr_m1     = xfer & PWRITE & hit_m1;
  wire                 wr_m2     = xfer & PWRITE & hit_m2;
  // result registers ignore writes and answer without error
  wire                 rd_low    = xfer & ~PWRITE & hit_res & ~res_high;
  wire                 start_wr  = wr_m1 & PWDATA[M1_START_BIT];

  // read data, start reads 0
  wire [7:0] m1_rd = {end_q, busy_q, repeat_q, scan_q, 1'b0, 1'b0, 2'b00};
  wire [7:0] m2_rd = {2'b00, speed_q, ref_on_q, ch_sel_q};
  wire [SAS_RES_W-1:0] res_sel = res_q[res_pair];
  wire [7:0] res_lo = {res_sel[1:0], 6'h00};
  wire [7:0] res_hi = res_sel[SAS_RES_W-1:2];
  wire [7:0] rd_byte = hit_m1  ? m1_rd :
                       hit_m2  ? m2_rd :
                       res_high ? res_hi : res_lo;

  // ---------------- sequencer decode ----------------
  // scan starts at 0 or 4 and covers ch_sel[1:0]+1 channels
  wire [SAS_CH_W-1:0] scan_first = {ch_sel_q[2], 2'b00};
  wire [SAS_CH_W-1:0] first_ch   = scan_q ? scan_first : ch_sel_q;
  wire [SAS_CH_W-1:0] last_ch    = ch_sel_q;
  wire [7:0] bit_cyc = (speed_q == 2'd0) ? 8'(BIT_CYC_0 - 1) :
                       (speed_q == 2'd1) ? 8'(BIT_CYC_1 - 1) :
                       (speed_q == 2'd2) ? 8'(BIT_CYC_2 - 1) :
                                           8'(BIT_CYC_3 - 1);
  wire bit_done  = (state_q == SAS_BIT) & (cnt_q == 8'h00);
  // keep the trial bit when the input is at or above the ladder tap
  wire [SAS_RES_W-1:0] code_keep = cmp_s_q ? code_q : (code_q & ~mask_q);
  wire [SAS_RES_W-1:0] code_next = code_keep | (mask_q >> 1);
  wire pass_last = (ch_q == last_q);
  wire seq_end   = (state_q == SAS_STORE) & pass_last & ~repeat_q;
  wire pass_end  = (state_q == SAS_STORE) & pass_last;
  wire [SAS_NCH-1:0] ch_onehot = SAS_NCH'(1) << ch_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      SAS_IDLE:  if (start_wr) state_d = SAS_BIT;
      SAS_BIT:   if (bit_done && mask_q[0]) state_d = SAS_STORE;
      SAS_STORE: state_d = seq_end ? SAS_IDLE : SAS_BIT;
      default:   state_d = SAS_IDLE;
    endcase
  end

  // ---------------- apb answer: one wait state ----------------
  // answer follows the first access cycle; a fixed wait keeps the master logic simple
  wire        ans_cyc   = acc_phase & ~pready_q;
  wire        pready_d  = ans_cyc;
  wire        pslverr_d = ans_cyc & ~mapped;
  wire [31:0] prdata_d  = (ans_cyc & mapped & ~PWRITE) ? {24'h00_0000, rd_byte}
                                                       : 32'h0000_0000;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= pslverr_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // ---------------- control register next values ----------------
  wire                repeat_d = wr_m1 ? PWDATA[M1_REPEAT_BIT] : repeat_q;
  wire                scan_d   = wr_m1 ? PWDATA[M1_SCAN_BIT] : scan_q;
  wire [SAS_CH_W-1:0] ch_sel_d = wr_m2 ? PWDATA[M2_CH_LSB +: SAS_CH_W] : ch_sel_q;
  wire                ref_on_d = wr_m2 ? PWDATA[M2_REF_BIT] : ref_on_q;
  wire [1:0]          speed_d  = wr_m2 ? PWDATA[M2_SPEED_LSB +: 2] : speed_q;

  // ---------------- control registers ----------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      repeat_q <= RST_FLAG;
    end else begin
      repeat_q <= repeat_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      scan_q <= RST_FLAG;
    end else begin
      scan_q <= scan_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ch_sel_q <= RST_CH_SEL;
    end else begin
      ch_sel_q <= ch_sel_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ref_on_q <= RST_REF_ON;
    end else begin
      ref_on_q <= ref_on_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      speed_q <= RST_SPEED;
    end else begin
      speed_q <= speed_d;
    end
  end

  // ---------------- flag next values ----------------
  wire seq_start = (state_q == SAS_IDLE) & start_wr;
  // a start written while busy is dropped, so a running pass is never torn
  wire busy_d    = seq_start ? 1'b1 : seq_end ? 1'b0 : busy_q;
  // a pass ending in the same cycle as a low byte read wins
  wire end_d     = pass_end ? 1'b1 : (rd_low | seq_start) ? 1'b0 : end_q;
  wire irq_d     = seq_end;

  // ---------------- busy and end flags ----------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      busy_q <= RST_FLAG;
    end else begin
      busy_q <= busy_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      end_q <= RST_FLAG;
    end else begin
      end_q <= end_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ---------------- sequencer next values ----------------
  wire                 in_bit    = (state_q == SAS_BIT);
  wire                 pass_more = (state_q == SAS_STORE) & ~seq_end;
  wire                 reload    = seq_start | pass_more;
  wire [SAS_RES_W-1:0] top_bit   = SAS_RES_W'(1) << (SAS_RES_W - 1);
  wire [SAS_RES_W-1:0] code_d    = reload ? top_bit : bit_done ? code_next : code_q;
  wire [SAS_RES_W-1:0] mask_d    = reload ? top_bit : bit_done ? (mask_q >> 1) : mask_q;
  wire [7:0]           cnt_d     = (reload | bit_done) ? bit_cyc :
                                   in_bit ? cnt_q - 8'h01 : cnt_q;
  // channel range latched so mid-pass writes do not tear a scan
  wire [SAS_CH_W-1:0]  next_ch   = pass_last ? first_q : ch_q + 3'h1;
  wire [SAS_CH_W-1:0]  ch_d      = seq_start ? first_ch : pass_more ? next_ch : ch_q;
  wire [SAS_CH_W-1:0]  first_d   = seq_start ? first_ch : first_q;
  wire [SAS_CH_W-1:0]  last_d    = seq_start ? (scan_q ? last_ch : ch_sel_q)
                                             : last_q;

  // ---------------- successive approximation ----------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_q <= SAS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      code_q <= '0;
    end else begin
      code_q <= code_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      mask_q <= '0;
    end else begin
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ch_q <= RST_CH_SEL;
    end else begin
      ch_q <= ch_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      first_q <= RST_CH_SEL;
    end else begin
      first_q <= first_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      last_q <= RST_CH_SEL;
    end else begin
      last_q <= last_d;
    end
  end

  // results carry no channel identity and are never reset
  always_ff @(posedge CLK_SYS) begin
    if (state_q == SAS_STORE) begin
      res_q[ch_q[1:0]] <= code_q;
    end
  end

  // ---------------- pin synchronisers and digital port ----------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cmp_m_q <= 1'b0;
      cmp_s_q <= 1'b0;
      pin_m_q <= '0;
      pin_s_q <= '0;
      port_q  <= '0;
    end else begin
      cmp_m_q <= CMP_GE;
      cmp_s_q <= cmp_m_q;
      pin_m_q <= PIN_LEVEL;
      pin_s_q <= pin_m_q;
      // only the pin under conversion is masked; the rest read normally
      port_q  <= pin_s_q & ~(busy_q ? ch_onehot : '0);
    end
  end

  assign PRDATA        = prdata_q;
  assign PREADY        = pready_q;
  assign PSLVERR       = pslverr_q;
  assign LADDER_CODE   = code_q;
  assign ANALOG_CH     = ch_q;
  assign REF_GATE_ON   = ref_on_q;
  assign CONV_DONE_IRQ = irq_q;
  assign PORT_DIN      = port_q;
endmodule // sas_top

//--- testbench/sas_afe_model.sv
// model: analog front end with an ideal reference ladder and comparator
`timescale 1ns/10ps
module sas_afe_model
  import sas_pkg::*;
(
  // sequencer side
  input  wire logic [sas_pkg::SAS_RES_W-1:0]                  ladder_code,
  input  wire logic [sas_pkg::SAS_CH_W-1:0]                   analog_ch,
  input  wire logic                                           ref_gate_on,
  // input voltages as codes, channel 0 lowest
  input  wire logic [sas_pkg::SAS_NCH*sas_pkg::SAS_RES_W-1:0] vin_flat,
  output logic                                                cmp_ge
);
  import sas_pkg::*;
  logic [SAS_RES_W-1:0] vin_sel;
  assign vin_sel = vin_flat[analog_ch*SAS_RES_W +: SAS_RES_W];
  // ladder switch open: every tap sits at the low reference, so the input always wins
  assign cmp_ge = ref_gate_on ? (vin_sel >= ladder_code) : 1'b1;
endmodule // sas_afe_model

//--- testbench/sas_checker.sv
// checker: port-level assertions for the adc sequencer
`timescale 1ns/10ps
module sas_checker
  import sas_pkg::*;
(
  // clock and reset
  input wire logic                            CLK_SYS,
  input wire logic                            RST,
  // apb
  input wire logic                            PSEL,
  input wire logic                            PENABLE,
  input wire logic                            PWRITE,
  input wire logic [sas_pkg::SAS_ADDR_W-1:0]  PADDR,
  input wire logic [31:0]                     PWDATA,
  input wire logic [31:0]                     PRDATA,
  input wire logic                            PREADY,
  input wire logic                            PSLVERR,
  // analog front end
  input wire logic                            CMP_GE,
  input wire logic [sas_pkg::SAS_RES_W-1:0]   LADDER_CODE,
  input wire logic [sas_pkg::SAS_CH_W-1:0]    ANALOG_CH,
  input wire logic                            REF_GATE_ON,
  input wire logic                            CONV_DONE_IRQ,
  // digital port
  input wire logic [sas_pkg::SAS_NCH-1:0]     PIN_LEVEL,
  input wire logic [sas_pkg::SAS_NCH-1:0]     PORT_DIN
);
  import sas_pkg::*;
  localparam logic [11:0] A_M1 = {IDX_CONV_MODE_CTRL_1, 2'b00};
  localparam logic [11:0] A_M2 = {IDX_CONV_MODE_CTRL_2, 2'b00};
  logic [2:0] age_q;
  logic [2:0] ch_q;
  // pin checks wait until the synchroniser has refilled after reset
  always_ff @(posedge CLK_SYS) begin
    age_q <= RST ? 3'h0 : age_q + 3'(age_q != 3'h4);
    ch_q  <= ANALOG_CH;
  end
  wire logic map_ok = PADDR[1:0] == 2'b00 && PADDR[11:2] >= IDX_CONV_MODE_CTRL_1
                      && PADDR[11:2] <= IDX_RESULT_CH3_7_HIGH;
  wire logic ref_bit = PWDATA[M2_REF_BIT];
  wire logic [7:0] mask = (8'h01 << ANALOG_CH) | (8'h01 << ch_q);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  chk_ready_one_wait: assert property ($rose(PSEL && PENABLE) |-> !PREADY ##1 PREADY)
    else $error("pready not after one wait state");
  chk_rdata_idle: assert property (PRDATA[31:8] == 24'h0 && (PREADY || PRDATA[7:0] == 8'h00))
    else $error("prdata not zero outside answer");
  chk_err_unmapped: assert property (PREADY |-> PSLVERR == !map_ok)
    else $error("pslverr wrong for address");
  chk_start_reads0: assert property (PREADY && !PWRITE && PADDR == A_M1 |-> PRDATA[3:0] == 4'h0)
    else $error("start bit read not zero");
  chk_ref_follow: assert property (PREADY && PWRITE && PADDR == A_M2 |=> REF_GATE_ON == $past(ref_bit))
    else $error("reference gate not following write");
  chk_reset_vals: assert property ($fell(RST) |-> ANALOG_CH == 3'h0 && LADDER_CODE == 10'h000
    && !REF_GATE_ON && !CONV_DONE_IRQ) else $error("outputs not at reset values");
  chk_irq_pulse: assert property (CONV_DONE_IRQ |=> !CONV_DONE_IRQ)
    else $error("interrupt longer than one cycle");
  chk_port_pins: assert property (age_q == 3'h4 |-> (PORT_DIN | mask) == ($past(PIN_LEVEL, 3) | mask))
    else $error("port input not following pins");
  cover property (CONV_DONE_IRQ);
  cover property (PREADY && PSLVERR);
  cover property (PREADY && PWRITE && PADDR == A_M1);
endmodule // sas_checker

bind sas_top sas_checker chk_u (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .CMP_GE(CMP_GE), .LADDER_CODE(LADDER_CODE), .ANALOG_CH(ANALOG_CH),
  .REF_GATE_ON(REF_GATE_ON), .CONV_DONE_IRQ(CONV_DONE_IRQ), .PIN_LEVEL(PIN_LEVEL),
  .PORT_DIN(PORT_DIN));

//--- testbench/tb.sv
// testbench: apb-driven checks of the adc sequencer against an ideal front end
`timescale 1ns/10ps
module tb;
  import sas_pkg::*;
  localparam logic [11:0] A_M1 = {IDX_CONV_MODE_CTRL_1, 2'b00};
  localparam logic [11:0] A_M2 = {IDX_CONV_MODE_CTRL_2, 2'b00};
  localparam logic [11:0] A_RS = {IDX_RESULT_CH0_4_LOW, 2'b00};
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  pin_level = 8'h00;
  logic [31:0] prdata;
  logic        pready, pslverr, cmp_ge, ref_on, irq, rd_err;
  logic [9:0]  ladder;
  logic [2:0]  ach;
  logic [7:0]  port_din, rd;
  logic [9:0]  vin [8] = '{default: 10'h0};
  logic [9:0]  expv [4];
  logic [79:0] vin_flat;
  int          miscompares = 0;
  int          n_tests = 0;
  int          irq_cnt = 0;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (irq === 1'b1) irq_cnt++;
  always_comb for (int i = 0; i < 8; i++) vin_flat[i*10 +: 10] = vin[i];
  sas_top dut_u (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CMP_GE(cmp_ge), .LADDER_CODE(ladder), .ANALOG_CH(ach), .REF_GATE_ON(ref_on),
    .CONV_DONE_IRQ(irq), .PIN_LEVEL(pin_level), .PORT_DIN(port_din));
  sas_afe_model afe_u (.ladder_code(ladder), .analog_ch(ach), .ref_gate_on(ref_on),
    .vin_flat(vin_flat), .cmp_ge(cmp_ge));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic int first_ch(input logic scan, input logic [2:0] sel);
    return scan ? {sel[2], 2'b00} : sel;
  endfunction
  task automatic run(input logic scan, input logic [2:0] sel, input logic [1:0] spd);
    int k;
    int irq0;
    for (k = 0; k < 8; k++) vin[k] <= 10'($urandom);
    pin_level <= 8'($urandom);
    apb(A_M2, 1'b1, {2'b00, spd, 1'b1, sel});
    apb(A_M1, 1'b1, {3'b000, scan, 4'b0100});
    irq0 = irq_cnt;
    apb(A_M1, 1'b0, 8'h00);
    check("busy after start", 16'h1, 16'(rd[6]));
    for (k = 0; k < 500 && rd[7] !== 1'b1; k++) apb(A_M1, 1'b0, 8'h00);
    check("mode after end", 16'({1'b1, 2'b00, scan, 4'h0}), 16'(rd));
    check("irq count", 16'(irq0 + 1), 16'(irq_cnt));
    apb(A_RS + 12'(8 * (sel % 4) + 4), 1'b0, 8'h00);
    apb(A_M1, 1'b0, 8'h00);
    check("end after high read", 16'h1, 16'(rd[7]));
    for (k = first_ch(scan, sel); k <= sel; k++) begin
      expv[k % 4] = vin[k];
      apb(A_RS + 12'(8 * (k % 4) + 4), 1'b0, 8'h00);
      check("result high", 16'(vin[k][9:2]), 16'(rd));
      apb(A_RS + 12'(8 * (k % 4)), 1'b0, 8'h00);
      check("result low", 16'({vin[k][1:0], 6'h00}), 16'(rd));
    end
    apb(A_M1, 1'b0, 8'h00);
    check("end after low read", 16'h0, 16'(rd[7]));
  endtask
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(32'haeb1));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    apb(A_M1, 1'b0, 8'h00);
    check("mode1 reset", 16'h0, 16'(rd));
    apb(A_M2, 1'b0, 8'h00);
    check("mode2 reset", 16'h0, 16'(rd));
    apb(12'h200, 1'b0, 8'h00);
    check("unmapped error", 16'h1, 16'(rd_err));
    apb(A_M2, 1'b1, 8'h08);
    repeat (150) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) run(1'b0, 3'(i), 2'($urandom));
    for (int i = 0; i < 8; i++) run(1'b1, 3'(i), 2'b00);
    for (int p = 0; p < 4; p++) begin
      apb(A_RS + 12'(8 * p + 4), 1'b1, 8'h5a);
      apb(A_RS + 12'(8 * p + 4), 1'b0, 8'h00);
      check("read-only result", 16'(expv[p][9:2]), 16'(rd));
    end
    apb(A_M2, 1'b1, 8'h0d);
    apb(A_M1, 1'b1, 8'h34);
    repeat (1500) @(posedge clk_sys);
    apb(A_M1, 1'b0, 8'h00);
    check("repeat flags", 16'h3, 16'(rd[7:6]));
    apb(A_M1, 1'b1, 8'h10);
    for (int k = 0; k < 200 && rd[6] !== 1'b0; k++) apb(A_M1, 1'b0, 8'h00);
    repeat (400) @(posedge clk_sys);
    apb(A_M1, 1'b0, 8'h00);
    check("busy after repeat off", 16'h0, 16'(rd[6]));
    apb(A_M1, 1'b1, 8'h04);
    apb(A_M1, 1'b1, 8'h14);
    apb(A_M1, 1'b0, 8'h00);
    check("restart while busy", 16'h50, 16'(rd));
    // reset in mid-conversion must drop every flag and field
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    apb(A_M1, 1'b0, 8'h00);
    check("mode1 after mid reset", 16'h0, 16'(rd));
    apb(A_M2, 1'b0, 8'h00);
    check("mode2 after mid reset", 16'h0, 16'(rd));
    apb(A_M2, 1'b1, 8'h00);
    stop_test();
  end
  // the full sequence needs well under a third of this span
  initial begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    stop_test();
  end
endmodule // tb
